// file: esoc_pkg.sv
// esoc_pkg: shared types and constants for the external select output control
// assumes a two-wire serial bus sampled by a 10 MHz core clock
package esoc_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned CTRL_OE_BIT    = 1;
    localparam int unsigned CTRL_RW_BIT    = 0;
    localparam int unsigned BYTE_BITS      = 8;
    localparam logic        SEL_RESET_ON   = 1'b0;
    localparam logic [3:0]  CTRL_CODE_VAL  = 4'h6;

    // decoded bus events from the edge finder
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
    } esoc_bus_ev_s;

    typedef enum logic [2:0] {
        ESOC_IDLE,
        ESOC_CTRL,
        ESOC_ID,
        ESOC_REST,
        ESOC_IGNORE
    } esoc_state_e;
endpackage : esoc_pkg

// file: esoc_edge_det.sv
// esoc_edge_det: synchronises the serial clock and data pins and finds
// start, stop and clock edges; assumes both pins arrive asynchronously
`timescale 1ns/10ps
`default_nettype none
module esoc_edge_det
    import esoc_pkg::*;
(
    input  wire logic         core_clk_i,
    input  wire logic         nrst_i,
    input  wire logic         scl_i,
    input  wire logic         sda_i,
    output var  esoc_bus_ev_s ev_o
);
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic       scl_d_ff;
    logic       sda_d_ff;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            scl_d_ff    <= scl_sync_ff[1];
            sda_d_ff    <= sda_sync_ff[1];
        end
    end

    wire scl_s = scl_sync_ff[1];
    wire sda_s = sda_sync_ff[1];

    assign ev_o.scl_rise = scl_s & ~scl_d_ff;
    assign ev_o.scl_fall = ~scl_s & scl_d_ff;
    // data moving while clock is high marks start and stop
    assign ev_o.start    = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign ev_o.stop     = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign ev_o.sda      = sda_s;
endmodule // esoc_edge_det
`default_nettype wire

// file: esoc_ctrl.sv
// esoc_ctrl: drives the open-drain active-low select output from the
// enable bit of each matched command's control byte
// assumes a bus master and an external pull-up on the select line
`timescale 1ns/10ps
`default_nettype none
module esoc_ctrl
    import esoc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [7:0] dev_id_i,
    output logic            ext_select_out_n_o,
    output logic            ext_select_out_n_oe_o,
    output logic            sda_o,
    output logic            sda_oe_o
);
    esoc_bus_ev_s ev;

    esoc_edge_det u_edge (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .ev_o       (ev)
    );

    esoc_state_e state_ff;
    esoc_state_e nxt_state;
    logic [3:0]  bit_cnt_ff;
    logic [7:0]  shift_ff;
    logic        oe_bit_ff;
    logic        rw_bit_ff;
    logic        id_ok_ff;
    logic        pend_ff;
    logic        ack_drv_ff;
    logic        sel_on_ff;
    logic        last_rise_ff;

    function automatic logic is_ctrl_code(input logic [7:0] b);
        return b[7:4] == CTRL_CODE_VAL;
    endfunction

    wire        byte_done = ev.scl_rise && bit_cnt_ff == 4'(BYTE_BITS - 1);
    wire [7:0]  byte_val  = {shift_ff[6:0], ev.sda};
    wire        ack_rise  = ev.scl_rise && bit_cnt_ff == 4'(BYTE_BITS);
    // command type is not decoded: every matched command applies at the
    // first rise after the id acknowledge, which is also the rise before a short stop
    wire        early_cmd = (state_ff == ESOC_ID) && id_ok_ff && ack_rise;
    // rising edge of the ack clock counted, next rise applies
    logic       early_go_ff;
    wire        apply_early = early_go_ff && ev.scl_rise && pend_ff;
    // backstop only: the acknowledge holds data low, so no stop can
    // come between the id ack rise and the next rise
    wire        apply_stop  = ev.stop && pend_ff && last_rise_ff;

    always_comb begin
        nxt_state = state_ff;
        if (ev.start) begin
            nxt_state = ESOC_CTRL;
        end else if (ev.stop) begin
            nxt_state = ESOC_IDLE;
        end else begin
            unique case (state_ff)
                ESOC_IDLE:   nxt_state = ESOC_IDLE;
                ESOC_CTRL:   if (ack_rise) nxt_state = is_ctrl_code(shift_ff) ? ESOC_ID
                                                                    : ESOC_IGNORE;
                ESOC_ID:     if (ack_rise) nxt_state = id_ok_ff ? ESOC_REST : ESOC_IGNORE;
                ESOC_REST:   nxt_state = ESOC_REST;
                ESOC_IGNORE: nxt_state = ESOC_IGNORE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff   <= ESOC_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            if (ev.start || (ack_rise)) begin
                bit_cnt_ff <= 4'h0;
            end else if (ev.scl_rise) begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            if (ev.scl_rise && bit_cnt_ff < 4'(BYTE_BITS)) begin
                shift_ff <= byte_val;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            oe_bit_ff <= 1'b0;
            rw_bit_ff <= 1'b0;
            id_ok_ff  <= 1'b0;
        end else if (byte_done && state_ff == ESOC_CTRL) begin
            oe_bit_ff <= byte_val[CTRL_OE_BIT];
            rw_bit_ff <= byte_val[CTRL_RW_BIT];
        end else if (byte_done && state_ff == ESOC_ID) begin
            id_ok_ff  <= byte_val == dev_id_i;
        end
    end

    // pend: a matched command whose setting is not yet applied
    // last_rise: clock high since its last rise, so a stop qualifies
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_ff      <= 1'b0;
            early_go_ff  <= 1'b0;
            last_rise_ff <= 1'b0;
        end else begin
            last_rise_ff <= ev.scl_rise ? 1'b1 : (ev.scl_fall ? 1'b0 : last_rise_ff);
            if (ev.start) begin
                pend_ff     <= 1'b0;
                early_go_ff <= 1'b0;
            end else if (state_ff == ESOC_ID && ack_rise && id_ok_ff) begin
                pend_ff     <= 1'b1;
                early_go_ff <= early_cmd;
            end else if (apply_early || apply_stop) begin
                pend_ff     <= 1'b0;
                early_go_ff <= 1'b0;
            end
        end
    end

    // held latch: only a matched command changes it
    // nrst_i stands in for power-up; there is no other clear
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_on_ff <= SEL_RESET_ON;
        end else if (apply_early || apply_stop) begin
            sel_on_ff <= oe_bit_ff;
        end
    end

    // acknowledge during ninth clock of control and ID bytes
    // released on the ninth fall so the master can move data next
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_drv_ff <= 1'b0;
        end else if (ev.start || ev.stop) begin
            ack_drv_ff <= 1'b0;
        end else if (ev.scl_fall && bit_cnt_ff == 4'(BYTE_BITS)) begin
            ack_drv_ff <= (state_ff == ESOC_CTRL && is_ctrl_code(shift_ff))
                          || (state_ff == ESOC_ID && id_ok_ff);
        end else if (ev.scl_fall) begin
            ack_drv_ff <= 1'b0;
        end
    end

    // open drain: only ever drive low
    assign ext_select_out_n_o    = 1'b0;
    assign ext_select_out_n_oe_o = sel_on_ff;
    assign sda_o                 = 1'b0;
    assign sda_oe_o              = ack_drv_ff;

    // checks on the apply edge, the held latch and the captured fields
    a_sel_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !(apply_early || apply_stop) |=> $stable(sel_on_ff))
        else $error("select changed without command");
    a_sel_value: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (apply_early || apply_stop) |=> sel_on_ff == $past(oe_bit_ff))
        else $error("select differs from enable bit");
    a_early_edge: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        apply_early |-> state_ff == ESOC_REST && bit_cnt_ff == 4'h0)
        else $error("apply not on first rise after ack");
    a_early_value: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        apply_early && oe_bit_ff |=> ext_select_out_n_oe_o)
        else $error("select not pulled after ack");
    a_stop_edge: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ev.stop && state_ff == ESOC_REST |-> !pend_ff && sel_on_ff == oe_bit_ff)
        else $error("select not updated before stop");
    a_drive_low: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ext_select_out_n_oe_o |-> ext_select_out_n_o == 1'b0)
        else $error("select driven high");
    a_release_off: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (apply_early || apply_stop) && !oe_bit_ff |=> !ext_select_out_n_oe_o)
        else $error("cleared enable not released");
    a_pend_clear: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (apply_early || apply_stop) |=> !pend_ff)
        else $error("pending not cleared");
    a_id_gate: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        $rose(pend_ff) |-> $past(id_ok_ff))
        else $error("pending without matched ID");
    a_id_capture: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        byte_done && state_ff == ESOC_ID |=> id_ok_ff == (shift_ff == dev_id_i))
        else $error("id match not captured");
    a_oe_capture: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        byte_done && state_ff == ESOC_CTRL |=> oe_bit_ff == shift_ff[CTRL_OE_BIT])
        else $error("enable bit not captured");
    a_start_cancel: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ev.start |=> !pend_ff && state_ff == ESOC_CTRL)
        else $error("start left a pending change");
    a_refused_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        state_ff == ESOC_IGNORE |-> !pend_ff)
        else $error("refused command pending");
    a_ack_match: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        $rose(ack_drv_ff) |-> $past(state_ff) == ESOC_CTRL || $past(state_ff) == ESOC_ID)
        else $error("acknowledge outside control or id byte");
    a_ack_release: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (ev.start || ev.stop) |=> !ack_drv_ff)
        else $error("acknowledge held over start or stop");
    a_cnt_range: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        bit_cnt_ff <= 4'(BYTE_BITS))
        else $error("bit counter past ack");

    // covers for the main scenarios
    c_early: cover property (@(posedge core_clk_i) apply_early && oe_bit_ff);
    c_read_early: cover property (@(posedge core_clk_i) apply_early && rw_bit_ff);
    c_stop_on: cover property (@(posedge core_clk_i)
        ev.stop && state_ff == ESOC_REST && sel_on_ff);
    c_stop_off: cover property (@(posedge core_clk_i)
        ev.stop && state_ff == ESOC_REST && !sel_on_ff);
    c_refused: cover property (@(posedge core_clk_i) ev.stop && state_ff == ESOC_IGNORE);
endmodule // esoc_ctrl
`default_nettype wire

// file: esoc_master.sv
// esoc_master: two-wire bus master model that issues commands
// assumes the bench resolves the open-drain lines with pull-ups
`timescale 1ns/10ps
`default_nettype none
module esoc_master (
    input  wire logic core_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // scl moves first, so data changes while the clock is high only in the start and stop halves
    task automatic half(input logic scl, input logic pull);
        @(posedge core_clk_i);
        scl_o <= scl;
        @(posedge core_clk_i);
        sda_oe_o <= pull;
        repeat (2) @(posedge core_clk_i);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            half(1'b0, ~b[i]);
            half(1'b1, ~b[i]);
        end
        half(1'b0, 1'b0);
        half(1'b1, 1'b0);
        ack = sda_i;
    endtask
    // short form: control byte and id byte, then stop
    task automatic cmd(input logic [7:0] c, input logic [7:0] id, output logic ack);
        logic a0;
        half(1'b1, 1'b0);
        half(1'b1, 1'b1);
        half(1'b0, 1'b1);
        put_byte(c, a0);
        put_byte(id, ack);
        half(1'b0, 1'b1);
        half(1'b1, 1'b1);
        half(1'b1, 1'b0);
    endtask
endmodule // esoc_master
`default_nettype wire

// file: tb_top.sv
// tb_top: drives commands into the select control and checks the pin
// assumes pull-ups on the data and select lines
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %b expected %b", $time, g, e); end end
module tb_top;
    import esoc_pkg::*;
    logic       core_clk_i = 1'b0;
    logic       nrst_i     = 1'b0;
    logic [7:0] dev_id     = 8'h00;
    logic       scl, m_oe, d_sda, d_sda_oe, d_sel, d_sel_oe, sel_exp, got_ack;
    wire        sda_w = ~(m_oe | (d_sda_oe & ~d_sda));
    wire        sel_n = d_sel_oe ? d_sel : 1'b1;
    logic [1:0] exp_q[$];
    logic [1:0] exp_v;
    int         fails = 0, cmp_count = 0, seed = 84, cyc = 0;
    event       done_ev;
    always #50 core_clk_i = ~core_clk_i;
    esoc_master i_esoc_master (.core_clk_i(core_clk_i), .sda_i(sda_w),
        .scl_o(scl), .sda_oe_o(m_oe));
    esoc_ctrl i_esoc_ctrl (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .scl_i(scl),
        .sda_i(sda_w), .dev_id_i(dev_id), .ext_select_out_n_o(d_sel),
        .ext_select_out_n_oe_o(d_sel_oe), .sda_o(d_sda), .sda_oe_o(d_sda_oe));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // the expected pin follows only commands that are accepted
    task automatic run(input logic [7:0] c, input logic [7:0] id);
        logic ai;
        logic hit;
        hit = (c[7:4] == CTRL_CODE_VAL) && (id == dev_id);
        if (hit) begin
            sel_exp = ~c[CTRL_OE_BIT];
        end
        exp_q.push_back({~hit, sel_exp});
        i_esoc_master.cmd(c, id, ai);
        got_ack = ai;
        -> done_ev;
    endtask
    // change lands at the rise before the stop; checked 8 core cycles after the master releases data for the stop
    always begin
        @(done_ev);
        repeat (6) @(posedge core_clk_i);
        exp_v = exp_q.pop_front();
        `CHK({got_ack, sel_n}, exp_v)
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        logic [7:0] r;
        sel_exp = 1'b1;
        repeat (3) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        dev_id <= 8'($random(seed));
        repeat (4) @(posedge core_clk_i);
        `CHK(sel_n, 1'b1)
        $display("test power-up done");
        run(8'h62, dev_id);
        run(8'h60, dev_id ^ 8'h01);
        run(8'h52, dev_id);
        $display("test hold done");
        run(8'h61, dev_id);
        run(8'h63, dev_id);
        run(8'h60, dev_id);
        $display("test modes done");
        for (int k = 0; k < 8; k++) begin
            r = 8'($random(seed));
            run({CTRL_CODE_VAL, 2'b00, r[1:0]}, r[2] ? dev_id : r);
        end
        run(8'h62, dev_id);
        repeat (10) @(posedge core_clk_i);
        $display("test random done");
        // a mid-run reset must release a pulled select line
        nrst_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        `CHK(sel_n, 1'b1)
        $display("test reset done");
        conclude();
    end
endmodule // tb_top
`default_nettype wire
